// ### rtl/dual_slope_pwm_timer16.sv
`timescale 1ns/1ps
module dual_slope_pwm_timer16
  import pwm_timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output pins_type         pins
);

  typedef struct packed {
    logic [9:0]       pre_count;
    logic [15:0]      count_value;
    dir_type          dir;
    logic [7:0]       control_reg_a;
    logic [7:0]       control_reg_b;
    logic [2:0][15:0] cmp_buf;
    logic [2:0][15:0] compare_value;
    logic [15:0]      capture_value;
    logic [4:0]       flags;
    logic [2:0]       pin_direction_bit;
    logic [2:0]       level;
    logic [2:0]       oe;
    logic             awready;
    logic             wready;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } state_type;

  state_type   state_reg;
  state_type   state_next;
  logic [3:0]  waveform_mode_code;
  logic [15:0] top;
  logic        pc_mode;
  logic        pfc_mode;
  logic        fixed_top;
  logic        a_is_top;
  logic        capt_is_top;
  logic [9:0]  pre_limit;
  logic        tick;
  logic        wr_fire;
  logic        count_write;
  logic [15:0] next_count;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    return {strb[1] ? data[15:8] : old[15:8],
            strb[0] ? data[7:0]  : old[7:0]};
  endfunction : merge16

  // Mode decode and limit selection
  always_comb begin
    waveform_mode_code = {state_reg.control_reg_b[MODE_HIGH_POS +: 2],
                          state_reg.control_reg_a[MODE_LOW_POS +: 2]};
    pc_mode     = 1'b0;
    pfc_mode    = 1'b0;
    fixed_top   = 1'b0;
    a_is_top    = 1'b0;
    capt_is_top = 1'b0;
    top         = MAX_COUNT;
    case (waveform_mode_code)
      MODE_PC_8BIT: begin
        pc_mode   = 1'b1;
        fixed_top = 1'b1;
        top       = TOP_8BIT;
      end
      MODE_PC_9BIT: begin
        pc_mode   = 1'b1;
        fixed_top = 1'b1;
        top       = TOP_9BIT;
      end
      MODE_PC_10BIT: begin
        pc_mode   = 1'b1;
        fixed_top = 1'b1;
        top       = TOP_10BIT;
      end
      MODE_PC_CAPT: begin
        pc_mode     = 1'b1;
        capt_is_top = 1'b1;
        top         = state_reg.capture_value;
      end
      MODE_PC_CMPA: begin
        pc_mode  = 1'b1;
        a_is_top = 1'b1;
        top      = state_reg.compare_value[0];
      end
      MODE_PFC_CAPT: begin
        pfc_mode    = 1'b1;
        capt_is_top = 1'b1;
        top         = state_reg.capture_value;
      end
      MODE_PFC_CMPA: begin
        pfc_mode = 1'b1;
        a_is_top = 1'b1;
        top      = state_reg.compare_value[0];
      end
      default: begin
        top = MAX_COUNT;
      end
    endcase
  end

  // Prescaler select; a stopped clock select gives no tick
  always_comb begin
    case (state_reg.control_reg_b[CLK_SEL_POS +: 3])
      3'h1:    pre_limit = PRE_DIV_1;
      3'h2:    pre_limit = PRE_DIV_8;
      3'h3:    pre_limit = PRE_DIV_64;
      3'h4:    pre_limit = PRE_DIV_256;
      3'h5:    pre_limit = PRE_DIV_1024;
      default: pre_limit = PRE_DIV_1;
    endcase
  end

  assign tick = (state_reg.control_reg_b[CLK_SEL_POS +: 3] != 3'h0)
             && (state_reg.control_reg_b[CLK_SEL_POS +: 3] <= 3'h5)
             && (state_reg.pre_count == pre_limit);
  assign wr_fire     = state_reg.aw_got && state_reg.w_got
                    && !state_reg.bvalid;
  assign count_write = wr_fire && (state_reg.awaddr == COUNT_OFFSET);
  assign next_count  = (state_reg.dir == DIR_UP)
                     ? state_reg.count_value + 16'h0001
                     : state_reg.count_value - 16'h0001;

  // All next-state logic: bus, prescaler, counter, compare units
  always_comb begin
    logic [1:0]  act;
    logic [15:0] wval;
    act        = ACT_OFF;
    wval       = VALUE_RESET;
    state_next = state_reg;

    // Prescaler count, wraps at the selected divisor
    if (state_reg.control_reg_b[CLK_SEL_POS +: 3] == 3'h0 || tick) begin
      state_next.pre_count = 10'h000;
    end else begin
      state_next.pre_count = state_reg.pre_count + 10'h001;
    end

    // Non-PWM modes are outside this block: buffers pass straight through
    if (!pc_mode && !pfc_mode) begin
      state_next.compare_value = state_reg.cmp_buf;
    end

    // Bus write clears flags first so that hardware sets win
    if (wr_fire && state_reg.awaddr == FLAGS_OFFSET
        && state_reg.wstrb[0]) begin
      state_next.flags = state_reg.flags & ~state_reg.wdata[4:0];
    end

    // Compare units act on the count present during this tick
    for (int i = 0; i < 3; i++) begin
      act = state_reg.control_reg_a[ACTION_A_POS - 2 * i +: 2];
      if (tick && (pc_mode || pfc_mode)
          && state_reg.count_value == state_reg.compare_value[i]) begin
        state_next.flags[MATCH_A_POS + i] = 1'b1;
        case (act)
          ACT_TOGGLE: begin
            if (i == 0 && a_is_top) begin
              state_next.level[i] = ~state_reg.level[i];
            end
          end
          ACT_NONINV: begin
            state_next.level[i] = (state_reg.dir == DIR_DOWN);
          end
          ACT_INV: begin
            state_next.level[i] = (state_reg.dir == DIR_UP);
          end
          default: begin
            state_next.level[i] = state_reg.level[i];
          end
        endcase
      end
      // Pin only driven when an action owns it and direction is out
      state_next.oe[i] = state_reg.pin_direction_bit[i]
                      && act != ACT_OFF
                      && !(act == ACT_TOGGLE
                           && !(i == 0 && a_is_top));
    end

    // Dual-slope counter, direction turns on arrival at an end
    if (tick && (pc_mode || pfc_mode)) begin
      state_next.count_value = next_count;
      if (state_reg.dir == DIR_UP && next_count == top) begin
        state_next.dir = DIR_DOWN;
        if (a_is_top) begin
          state_next.flags[MATCH_A_POS] = 1'b1;
        end
        if (capt_is_top) begin
          state_next.flags[CAPTURE_POS] = 1'b1;
        end
        if (pc_mode) begin
          state_next.compare_value = state_reg.cmp_buf;
        end
      end else if (next_count == BOTTOM) begin
        state_next.dir = DIR_UP;
        state_next.flags[OVERFLOW_POS] = 1'b1;
        if (pfc_mode) begin
          state_next.compare_value = state_reg.cmp_buf;
        end
      end
    end

    // Write address and data are taken in either order
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.awaddr  = s_axi_awaddr;
      state_next.aw_got  = 1'b1;
      state_next.awready = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.wdata  = s_axi_wdata;
      state_next.wstrb  = s_axi_wstrb;
      state_next.w_got  = 1'b1;
      state_next.wready = 1'b0;
    end

    // Register write once both halves are held
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = RESP_OKAY;
      wval = merge16(VALUE_RESET, state_reg.wdata, state_reg.wstrb);
      if (fixed_top) begin
        wval = wval & top;
      end
      case (state_reg.awaddr)
        CTRL_A_OFFSET: begin
          if (state_reg.wstrb[0]) begin
            state_next.control_reg_a = state_reg.wdata[7:0];
          end
        end
        CTRL_B_OFFSET: begin
          if (state_reg.wstrb[0]) begin
            state_next.control_reg_b = {3'h0, state_reg.wdata[4:0]};
          end
        end
        COUNT_OFFSET: begin
          state_next.count_value = merge16(state_reg.count_value,
                                           state_reg.wdata,
                                           state_reg.wstrb);
        end
        COMPARE_A_OFFSET: state_next.cmp_buf[0] = wval;
        COMPARE_B_OFFSET: state_next.cmp_buf[1] = wval;
        COMPARE_C_OFFSET: state_next.cmp_buf[2] = wval;
        CAPTURE_OFFSET: begin
          state_next.capture_value = merge16(state_reg.capture_value,
                                             state_reg.wdata,
                                             state_reg.wstrb);
        end
        FLAGS_OFFSET: state_next.bresp = RESP_OKAY;
        PIN_DIR_OFFSET: begin
          if (state_reg.wstrb[0]) begin
            state_next.pin_direction_bit = state_reg.wdata[2:0];
          end
        end
        default: state_next.bresp = RESP_SLVERR;
      endcase
    end

    // Write answer; ready returns only after it is taken
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid  = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready  = 1'b1;
    end

    // Read: one-cycle answer from the registered image
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.arready = 1'b0;
      state_next.rvalid  = 1'b1;
      state_next.rresp   = RESP_OKAY;
      state_next.rdata   = 32'h0000_0000;
      case (s_axi_araddr)
        CTRL_A_OFFSET:    state_next.rdata[7:0] = state_reg.control_reg_a;
        CTRL_B_OFFSET:    state_next.rdata[7:0] = state_reg.control_reg_b;
        COUNT_OFFSET:     state_next.rdata[15:0] = state_reg.count_value;
        COMPARE_A_OFFSET: state_next.rdata[15:0] = state_reg.cmp_buf[0];
        COMPARE_B_OFFSET: state_next.rdata[15:0] = state_reg.cmp_buf[1];
        COMPARE_C_OFFSET: state_next.rdata[15:0] = state_reg.cmp_buf[2];
        CAPTURE_OFFSET:   state_next.rdata[15:0] = state_reg.capture_value;
        FLAGS_OFFSET:     state_next.rdata[4:0] = state_reg.flags;
        PIN_DIR_OFFSET:   state_next.rdata[2:0] = state_reg.pin_direction_bit;
        default:          state_next.rresp = RESP_SLVERR;
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid  = 1'b0;
      state_next.arready = 1'b1;
    end
  end

  // State register; bottom, upward, flags clear after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg         <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready  <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready  = state_reg.wready;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rresp   = state_reg.rresp;
  assign s_axi_rdata   = state_reg.rdata;
  assign pins.level    = state_reg.level;
  assign pins.oe       = state_reg.oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_turn_at_top: assert property (
    tick && (pc_mode || pfc_mode) && state_reg.dir == DIR_UP
    && next_count == top && !count_write
    |=> state_reg.dir == DIR_DOWN && state_reg.count_value == $past(top))
    else $error("counter did not turn at limit");

  a_count_holds: assert property (
    !tick && !count_write |=> $stable(state_reg.count_value))
    else $error("counter moved without a tick");

  a_pc_overflow: assert property (
    tick && pc_mode && state_reg.dir == DIR_DOWN
    && state_reg.count_value == 16'h0001 && !count_write
    |=> state_reg.flags[OVERFLOW_POS] && state_reg.dir == DIR_UP)
    else $error("overflow flag missing at bottom");

  a_pfc_reload: assert property (
    tick && pfc_mode && state_reg.dir == DIR_DOWN
    && state_reg.count_value == 16'h0001 && !count_write
    |=> state_reg.compare_value[0] == $past(state_reg.cmp_buf[0]))
    else $error("compare not reloaded at bottom");

  a_pc_reload: assert property (
    tick && pc_mode && state_reg.dir == DIR_UP && next_count == top
    && !count_write
    |=> state_reg.compare_value[1] == $past(state_reg.cmp_buf[1]))
    else $error("compare not reloaded at limit");

  a_fixed_mask: assert property (
    wr_fire && waveform_mode_code == MODE_PC_8BIT
    && state_reg.awaddr == COMPARE_B_OFFSET
    |=> state_reg.cmp_buf[1][15:8] == 8'h00)
    else $error("high compare bits not masked");

  a_pin_off: assert property (
    !state_reg.pin_direction_bit[2] |=> !pins.oe[2])
    else $error("pin driven while direction is input");

  a_up_clear: assert property (
    tick && (pc_mode || pfc_mode) && state_reg.dir == DIR_UP
    && state_reg.control_reg_a[7:6] == ACT_NONINV
    && state_reg.count_value == state_reg.compare_value[0]
    |=> !pins.level[0] ##0 state_reg.flags[MATCH_A_POS])
    else $error("up match did not clear output");

  c_top_turn: cover property (
    tick && pc_mode && state_reg.dir == DIR_UP && next_count == top);
  c_pfc_bottom: cover property (
    tick && pfc_mode && next_count == BOTTOM);
  c_bus_write: cover property (s_axi_bvalid && s_axi_bready);

endmodule : dual_slope_pwm_timer16

// ### inc/pwm_timer_pkg.sv
// How it works
// - Phase correct limit: fixed or capture/compare A
// - Count up to limit, then down to bottom
// - Count holds limit one timer tick
// - Phase correct sets overflow flag at bottom
// - Phase correct reloads compares at limit, flags
// - Fixed limit masks high compare bits on write
// - Action two non-inverted, three inverted PWM
// - Up match clears, down match sets output
// - Pin driven only when direction bit set
// - Bottom compare stays low, limit compare high
// - Mode 11 action one toggles channel A
// - Frequency correct limit: capture or compare A
// - Frequency correct reloads at bottom, sets overflow
// - Frequency correct limit flag set at limit
// - Mode 9 action one toggles channel A
// - Limits from 0x0003 up to 16 bits
// - Channel flag set on each compare match
// - Timer tick from prescaled clock divisors
// - Compare A buffered, capture immediate
// - Mode code split across two control registers
package pwm_timer_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_A_OFFSET    = 8'h00;
  localparam logic [7:0] CTRL_B_OFFSET    = 8'h04;
  localparam logic [7:0] COUNT_OFFSET     = 8'h08;
  localparam logic [7:0] COMPARE_A_OFFSET = 8'h0C;
  localparam logic [7:0] COMPARE_B_OFFSET = 8'h10;
  localparam logic [7:0] COMPARE_C_OFFSET = 8'h14;
  localparam logic [7:0] CAPTURE_OFFSET   = 8'h18;
  localparam logic [7:0] FLAGS_OFFSET     = 8'h1C;
  localparam logic [7:0] PIN_DIR_OFFSET   = 8'h20;

  // Field positions
  localparam int MODE_LOW_POS    = 0;  // control_reg_a [1:0]
  localparam int ACTION_A_POS    = 6;  // control_reg_a [7:6], B [5:4], C [3:2]
  localparam int MODE_HIGH_POS   = 3;  // control_reg_b [4:3]
  localparam int CLK_SEL_POS     = 0;  // control_reg_b [2:0]
  localparam int OVERFLOW_POS    = 0;  // flags [0]
  localparam int MATCH_A_POS     = 1;  // flags [3:1], one per channel
  localparam int CAPTURE_POS     = 4;  // flags [4]

  // Reset values and count limits
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [15:0] VALUE_RESET   = 16'h0000;
  localparam logic [15:0] BOTTOM        = 16'h0000;
  localparam logic [15:0] MAX_COUNT     = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [15:0] TOP_MIN       = 16'h0003;

  // Waveform mode codes
  localparam logic [3:0] MODE_PC_8BIT   = 4'h1;
  localparam logic [3:0] MODE_PC_9BIT   = 4'h2;
  localparam logic [3:0] MODE_PC_10BIT  = 4'h3;
  localparam logic [3:0] MODE_PFC_CAPT  = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA  = 4'h9;
  localparam logic [3:0] MODE_PC_CAPT   = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA   = 4'hB;

  // Output action codes
  localparam logic [1:0] ACT_OFF        = 2'h0;
  localparam logic [1:0] ACT_TOGGLE     = 2'h1;
  localparam logic [1:0] ACT_NONINV     = 2'h2;
  localparam logic [1:0] ACT_INV        = 2'h3;

  // Prescaler terminal counts (divisor minus one)
  localparam logic [9:0] PRE_DIV_1      = 10'h000;
  localparam logic [9:0] PRE_DIV_8      = 10'h007;
  localparam logic [9:0] PRE_DIV_64     = 10'h03F;
  localparam logic [9:0] PRE_DIV_256    = 10'h0FF;
  localparam logic [9:0] PRE_DIV_1024   = 10'h3FF;

  // Bus answers
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // Compare output pins
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] oe;
  } pins_type;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_type;

endpackage : pwm_timer_pkg

// ### test/dual_slope_pwm_timer16_tb_top.sv
`timescale 1ns/1ps
module dual_slope_pwm_timer16_tb_top;
  import pwm_timer_pkg::*;

  logic        clk;
  logic        reset_n;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  pins_type    pins;
  int          miscompares;
  int          checks_done;

  dual_slope_pwm_timer16 i_dual_slope_pwm_timer16 (
    .clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pins(pins)
  );

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task close_out;
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  // Full reset between scenarios, so count and direction start clean
  task do_reset(input int n);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset

  // Address and data offered together, each dropped when taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic aw;
    logic w;
    logic b;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b && n < 100) begin
      @(posedge clk);
      n++;
      if (!aw && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (!w && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b1;
      end
      if (aw && w && s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        b = 1'b1;
        check("write response", 32'(er), 32'(s_axi_bresp));
      end
    end
    check("write answer", 32'h0000_0001, 32'(b));
  endtask : wr

  task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int   n;
    logic ar;
    logic r;
    n = 0;
    ar = 1'b0;
    r = 1'b0;
    d = 32'h0000_0000;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r && n < 100) begin
      @(posedge clk);
      n++;
      if (!ar && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        ar = 1'b1;
      end
      if (ar && s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        r = 1'b1;
        d = s_axi_rdata;
        check("read response", 32'(er), 32'(s_axi_rresp));
      end
    end
    check("read answer", 32'h0000_0001, 32'(r));
  endtask : rd

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, RESP_OKAY, d);
    check(what, exp, d);
  endtask : rdchk

  // Buffers are written while the mode is still zero, clock stopped
  task cfg(input logic [3:0] m, input logic [5:0] act, input logic [15:0] cap,
           input logic [15:0] ca, input logic [15:0] cb,
           input logic [15:0] cc, input logic [2:0] dir);
    do_reset(2);
    wr(CAPTURE_OFFSET, {16'h0000, cap}, RESP_OKAY);
    wr(COMPARE_A_OFFSET, {16'h0000, ca}, RESP_OKAY);
    wr(COMPARE_B_OFFSET, {16'h0000, cb}, RESP_OKAY);
    wr(COMPARE_C_OFFSET, {16'h0000, cc}, RESP_OKAY);
    wr(PIN_DIR_OFFSET, {29'h0000_0000, dir}, RESP_OKAY);
    wr(CTRL_A_OFFSET, {24'h00_0000, act, m[1:0]}, RESP_OKAY);
    wr(CTRL_B_OFFSET, {27'h000_0000, m[3:2], 3'h0}, RESP_OKAY);
  endtask : cfg

  task go(input logic [3:0] m, input logic [2:0] sel);
    wr(CTRL_B_OFFSET, {27'h000_0000, m[3:2], sel}, RESP_OKAY);
  endtask : go

  // High time per channel over one window; negative expectation skips
  task measure(input int win, input int e0, input int e1, input int e2,
               input logic [2:0] oe_exp);
    int h[3];
    int e[3];
    h = '{0, 0, 0};
    e = '{e0, e1, e2};
    repeat (win + 20) @(posedge clk);
    for (int i = 0; i < win; i++) begin
      @(negedge clk);
      for (int k = 0; k < 3; k++) begin
        if (pins.level[k] === 1'b1) h[k]++;
      end
    end
    for (int k = 0; k < 3; k++) begin
      if (e[k] >= 0) check($sformatf("high time ch%0d", k), e[k], h[k]);
    end
    check("output enables", 32'(oe_exp), 32'(pins.oe));
  endtask : measure

  task t_reset;
    logic [31:0] d;
    rdchk(COUNT_OFFSET, 32'h0000_0000, "count after reset");
    rdchk(FLAGS_OFFSET, 32'h0000_0000, "flags after reset");
    check("pins after reset", 32'h0000_0000, 32'(pins));
    rd(8'h40, RESP_SLVERR, d);
    check("unmapped read data", 32'h0000_0000, d);
    wr(8'h40, 32'h1234_5678, RESP_SLVERR);
    // Count is writable while stopped; the clock select is still zero
    wr(COUNT_OFFSET, 32'h0000_1234, RESP_OKAY);
    rdchk(COUNT_OFFSET, 32'h0000_1234, "count write");
    $display("test reset done");
  endtask : t_reset

  // Fixed limits clip compare writes, register-defined limits do not
  task t_mask;
    logic [3:0]  m;
    logic [15:0] lim;
    do_reset(2);
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? 4'h8 : 4'(i + 1);
      lim = (i == 3) ? MAX_COUNT : 16'((256 << i) - 1);
      wr(CTRL_A_OFFSET, {30'h0000_0000, m[1:0]}, RESP_OKAY);
      wr(CTRL_B_OFFSET, {27'h000_0000, m[3:2], 3'h0}, RESP_OKAY);
      wr(COMPARE_B_OFFSET, 32'h0000_FFFF, RESP_OKAY);
      rdchk(COMPARE_B_OFFSET, {16'h0000, lim}, "masked compare");
    end
    $display("test mask done");
  endtask : t_mask

  task t_fixed;
    int top;
    for (int i = 0; i < 3; i++) begin
      top = (256 << i) - 1;
      cfg(4'(i + 1), {ACT_OFF, ACT_NONINV, ACT_OFF}, 16'h0000, 16'h0000,
          16'h0040, 16'h0000, 3'h2);
      go(4'(i + 1), 3'h1);
      measure(2 * top, -1, 128, -1, 3'h2);
    end
    $display("test fixed limits done");
  endtask : t_fixed

  // Polarity, extremes, toggling and pin direction in three modes
  task t_levels;
    cfg(4'hA, {ACT_NONINV, ACT_INV, ACT_NONINV}, 16'h0028, 16'h000A,
        16'h000A, 16'h0028, 3'h3);
    go(4'hA, 3'h1);
    measure(80, 20, 60, 80, 3'h3);
    cfg(4'hB, {ACT_TOGGLE, ACT_NONINV, ACT_INV}, 16'h0000, 16'h0028,
        16'h0000, 16'h0028, 3'h7);
    go(4'hB, 3'h1);
    measure(160, 80, 0, 0, 3'h7);
    cfg(4'h9, {ACT_TOGGLE, ACT_INV, ACT_NONINV}, 16'h0000, 16'h0028,
        16'h0000, 16'h0019, 3'h7);
    go(4'h9, 3'h1);
    measure(160, 80, 160, 100, 3'h7);
    // Limit lowered on the fly, still above every compare value
    wr(COMPARE_A_OFFSET, 32'h0000_0020, RESP_OKAY);
    measure(128, 64, 128, 100, 3'h7);
    $display("test levels done");
  endtask : t_levels

  // Compare C sits above the limit and must never flag
  task t_flags;
    logic [3:0]  m;
    logic [31:0] exp;
    for (int i = 0; i < 4; i++) begin
      m = 4'(8 + i);
      exp = m[0] ? 32'h0000_0007 : 32'h0000_0017;
      cfg(m, 6'h00, 16'h0014, m[0] ? 16'h0014 : 16'h0005, 16'h000A,
          16'h001E, 3'h0);
      rdchk(FLAGS_OFFSET, 32'h0000_0000, "flags while stopped");
      go(m, 3'h1);
      repeat (100) @(posedge clk);
      rdchk(FLAGS_OFFSET, exp, "flags after run");
      go(m, 3'h0);
      wr(FLAGS_OFFSET, 32'h0000_001F, RESP_OKAY);
      rdchk(FLAGS_OFFSET, 32'h0000_0000, "flags cleared");
    end
    $display("test flags done");
  endtask : t_flags

  // Smallest limit at every divisor
  task t_prescale;
    int div;
    for (int s = 1; s <= 5; s++) begin
      div = (s == 1) ? 1 : (s == 2) ? 8 : (s == 3) ? 64 : (s == 4) ? 256 : 1024;
      cfg(4'h8, {ACT_NONINV, 4'h0}, TOP_MIN, 16'h0001, 16'h0000,
          16'h0000, 3'h1);
      go(4'h8, 3'(s));
      measure(6 * div, 2 * div, -1, -1, 3'h1);
    end
    $display("test prescale done");
  endtask : t_prescale

  // Main sequence
  initial begin
    reset_n = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    miscompares = 0;
    checks_done = 0;
    do_reset(6);
    t_reset;
    t_mask;
    t_fixed;
    t_levels;
    t_flags;
    t_prescale;
    close_out;
  end

  // Watchdog, well beyond the roughly 26k cycles the tests need
  initial begin
    #(2_000_000);
    miscompares++;
    $display("watchdog expired");
    close_out;
  end

endmodule : dual_slope_pwm_timer16_tb_top
